// >>> design/csb_converter_serial_block.v
// Function
// - word length 1 to 16 bits both ways
// - at most 16 slots, 256 bit clocks per frame
// - 4 words buffered each way
// - framing: multi-channel, I2S and link sync
// - enabled block owns all four pin directions
// - clock output selected: block drives its own bit clock
// - data out pin output only, driven while transmitting
// - idle bits: data out tri-stated or low per mode bit
// - data in pin input only while enabled
// - sync marks frames; both data lines align to it
// - sync pin direction follows its bit
// - engine uses shadow words while the user side moves words
// - short rx words left justified, low bits zero
// - short tx words from upper bits, low bits ignored
// - one 16-bit shift register, out and in together
// - words travel msb first
// - one 2-bit counter addresses both buffer halves
// - rx address: zero then the counter
// - tx address: one then the counter
`timescale 1ns/1ns
`default_nettype none
`include "csb_consts.vh"

module csb_converter_serial_block (
    // clock and reset
    input  wire                    clk,
    input  wire                    nrst,
    // configuration
    input  wire                    module_enable,
    input  wire                    bit_clock_direction_bit,
    input  wire                    frame_sync_direction_bit,
    input  wire                    output_idle_mode_bit,
    input  wire [1:0]              frame_mode,
    input  wire [3:0]              word_len_m1,
    input  wire [3:0]              slots_m1,
    input  wire [15:0]             slot_enable,
    // transmit words in
    input  wire                    tx_valid,
    output wire                    tx_ready,
    input  wire [`CSB_WORD_W-1:0]  tx_data,
    // receive words out
    output wire                    rx_valid,
    input  wire                    rx_ready,
    output wire [`CSB_WORD_W-1:0]  rx_data,
    // status pulses
    output wire                    tx_underflow,
    output wire                    rx_overflow,
    // pins
    input  wire                    serial_bit_clock_pin_i,
    output wire                    serial_bit_clock_pin_o,
    output wire                    serial_bit_clock_pin_oe,
    input  wire                    frame_sync_pin_i,
    output wire                    frame_sync_pin_o,
    output wire                    frame_sync_pin_oe,
    output wire                    serial_data_out_pin_o,
    output wire                    serial_data_out_pin_oe,
    input  wire                    serial_data_in_pin_i
);

localparam [7:0] HALF_M1 = `CSB_BCK_HALF_CYC - 1;

////////////////////////////////////////////////////////////////////////////////
// decoders

function slot_on;
    input [15:0] en_vec;
    input [3:0]  idx;
    begin
        slot_on = en_vec[idx];
    end
endfunction

// driven frame sync level at bit position q
function fs_level;
    input [1:0] mode;
    input [7:0] q;
    input [7:0] last;
    input [7:0] half;
    begin
        case (mode)
            `CSB_MODE_MULTI: fs_level = (q == last);
            `CSB_MODE_I2S:   fs_level = (q >= half - 8'h01) && (q != last);
            `CSB_MODE_AC16,
            `CSB_MODE_AC20:  fs_level = (q == last) || (q <= `CSB_AC_SYNC_LAST);
            default:         fs_level = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers, two stages before any use
reg sck_s1_ff, sck_s2_ff, fs_s1_ff, fs_s2_ff, sdi_s1_ff, sdi_s2_ff;

always @(posedge clk)
begin
    sck_s1_ff <= serial_bit_clock_pin_i;
    sck_s2_ff <= sck_s1_ff;
    fs_s1_ff  <= frame_sync_pin_i;
    fs_s2_ff  <= fs_s1_ff;
    sdi_s1_ff <= serial_data_in_pin_i;
    sdi_s2_ff <= sdi_s1_ff;
end

////////////////////////////////////////////////////////////////////////////////
// frame geometry
wire [8:0] fr_bits = ({5'h0, slots_m1} + 9'h001) * ({5'h0, word_len_m1} + 9'h001);
wire [7:0] fr_last = fr_bits[7:0] - 8'h01;
wire [7:0] fr_half = fr_bits[8:1];
wire       en      = module_enable;
wire       ck_in   = bit_clock_direction_bit;
wire       fs_in   = frame_sync_direction_bit;

////////////////////////////////////////////////////////////////////////////////
// bit clock divider, only when the block drives the clock
reg [7:0] div_ff;
reg       bck_gen_ff;

always @(posedge clk)
begin
    if (!nrst || !en || ck_in)
    begin
        div_ff     <= 8'h00;
        bck_gen_ff <= 1'b0;
    end
    else if (div_ff == HALF_M1)
    begin
        div_ff     <= 8'h00;
        bck_gen_ff <= ~bck_gen_ff;
    end
    else
        div_ff <= div_ff + 8'h01;
end

// edges: data changes on rising, is sampled on falling
reg  bck_prev_ff;
wire bck_lvl = ck_in ? sck_s2_ff : bck_gen_ff;
wire drv_ev  = en & bck_lvl & ~bck_prev_ff;
wire smp_ev  = en & ~bck_lvl & bck_prev_ff;

always @(posedge clk)
begin
    if (!nrst)
        bck_prev_ff <= 1'b0;
    else
        bck_prev_ff <= bck_lvl;
end

////////////////////////////////////////////////////////////////////////////////
// frame sync generator when this end is master
reg [7:0] mst_ff;
reg       fs_gen_ff;

always @(posedge clk)
begin
    if (!nrst || !en || fs_in)
    begin
        mst_ff    <= fr_last;
        fs_gen_ff <= 1'b0;
    end
    else if (drv_ev)
    begin
        mst_ff    <= (mst_ff == fr_last) ? 8'h00 : mst_ff + 8'h01;
        fs_gen_ff <= fs_level(frame_mode, (mst_ff == fr_last) ? 8'h00 : mst_ff + 8'h01,
                              fr_last, fr_half);
    end
end

////////////////////////////////////////////////////////////////////////////////
// frame start: rising sync, or falling word select in I2S
reg  fs_smp_ff;
wire fs_lvl    = fs_in ? fs_s2_ff : fs_gen_ff;
wire is_i2s    = (frame_mode == `CSB_MODE_I2S);
wire start_det = smp_ev & (is_i2s ? (fs_smp_ff & ~fs_lvl) : (~fs_smp_ff & fs_lvl));

always @(posedge clk)
begin
    if (!nrst)
        fs_smp_ff <= 1'b0;
    else if (smp_ev)
        fs_smp_ff <= fs_lvl;
end

////////////////////////////////////////////////////////////////////////////////
// serial engine state
reg                    in_frame_ff, ld_pend_ff, pf_pend_ff, pf_cap_ff, pf_ok_ff, cur_taken_ff;
reg [3:0]              wb_ff, slot_ff, pf_slot_ff;
reg [1:0]              cnt_ff;
reg [2:0]              tx_cnt_ff, rx_cnt_ff;
reg [`CSB_WORD_W-1:0]  sh_ff, pf_word_ff, hold_ff;
reg                    hold_vld_ff, tx_ready_ff, drn_tag_ff, udf_ff, ovf_ff;
reg                    sdo_ff, sdo_oe_ff, sck_o_ff, sck_oe_ff, fs_o_ff, fs_oe_ff;

wire                   last_bit  = in_frame_ff & (wb_ff == word_len_m1);
wire                   end_word  = smp_ev & last_bit;
wire                   eng_wr    = end_word & slot_on(slot_enable, slot_ff);
wire                   will_load = start_det | (end_word & (slot_ff != slots_m1));
wire [`CSB_WORD_W-1:0] sh_in     = {sh_ff[14:0], sdi_s2_ff};
wire [`CSB_WORD_W-1:0] rx_word   = sh_in << (4'hf - word_len_m1);
wire                   pf_act    = slot_on(slot_enable, pf_slot_ff);
wire                   pf_ok     = pf_act & (tx_cnt_ff != `CSB_RST_CNT);
wire                   usr_wr    = hold_vld_ff & ~eng_wr;
wire                   buf_ready;
wire                   drn_issue = ~pf_pend_ff & ~drn_tag_ff & buf_ready & (rx_cnt_ff != `CSB_RST_CNT);
wire [1:0]             rx_head   = cnt_ff - rx_cnt_ff[1:0];
wire [1:0]             tx_tail   = cnt_ff + tx_cnt_ff[1:0];
wire [`CSB_WORD_W-1:0] mem_rdata;

// shared counter addresses both shadow halves
wire [`CSB_MEM_AW-1:0] wr_addr = eng_wr ? {`CSB_RX_AREA, cnt_ff}
                                        : {`CSB_TX_AREA, tx_tail};
wire [`CSB_MEM_AW-1:0] rd_addr = pf_pend_ff ? {`CSB_TX_AREA, cnt_ff}
                                            : {`CSB_RX_AREA, rx_head};

csb_shadow_mem u_mem (
    .clk        (clk),
    .wr_en      (eng_wr | usr_wr),
    .wr_addr    (wr_addr),
    .wr_data    (eng_wr ? rx_word : hold_ff),
    .rd_en      (pf_pend_ff | drn_issue),
    .rd_addr    (rd_addr),
    .rd_data_ff (mem_rdata)
);

// word prefetch, a cycle after the deciding sample edge
always @(posedge clk)
begin
    if (!nrst || !en)
    begin
        pf_pend_ff <= 1'b0;
        pf_cap_ff  <= 1'b0;
        pf_ok_ff   <= 1'b0;
        pf_slot_ff <= 4'h0;
        pf_word_ff <= `CSB_RST_WORD;
        udf_ff     <= 1'b0;
    end
    else
    begin
        udf_ff <= 1'b0;
        if (will_load)
        begin
            pf_pend_ff <= 1'b1;
            pf_slot_ff <= start_det ? 4'h0 : slot_ff + 4'h1;
        end
        else
            pf_pend_ff <= 1'b0;
        if (pf_pend_ff)
        begin
            pf_ok_ff <= pf_ok;
            udf_ff   <= pf_act & ~pf_ok;   // underflow sends zeros
        end
        pf_cap_ff <= pf_pend_ff;
        if (pf_cap_ff)
            pf_word_ff <= mem_rdata;
    end
end

// bit timing, shift register and data output pin
always @(posedge clk)
begin
    if (!nrst || !en)
    begin
        in_frame_ff  <= 1'b0;
        ld_pend_ff   <= 1'b0;
        cur_taken_ff <= 1'b0;
        wb_ff        <= 4'h0;
        slot_ff      <= 4'h0;
        sh_ff        <= `CSB_RST_WORD;
        sdo_ff       <= 1'b0;
        sdo_oe_ff    <= 1'b0;
    end
    else
    begin
        if (will_load)
            ld_pend_ff <= 1'b1;
        if (smp_ev && in_frame_ff)
            sh_ff <= sh_in;
        if (drv_ev && ld_pend_ff)
        begin
            ld_pend_ff   <= 1'b0;
            in_frame_ff  <= 1'b1;
            wb_ff        <= 4'h0;
            slot_ff      <= pf_slot_ff;
            cur_taken_ff <= pf_ok_ff;
            sh_ff        <= pf_ok_ff ? pf_word_ff : `CSB_RST_WORD;
            sdo_ff       <= pf_ok_ff & pf_word_ff[15];
            sdo_oe_ff    <= slot_on(slot_enable, pf_slot_ff) | ~output_idle_mode_bit;
        end
        else if (drv_ev && in_frame_ff && last_bit)
        begin
            in_frame_ff <= 1'b0; // frame over, idle
            sdo_ff      <= 1'b0;
            sdo_oe_ff   <= ~output_idle_mode_bit;
        end
        else if (drv_ev && in_frame_ff)
        begin
            wb_ff     <= wb_ff + 4'h1;
            sdo_ff    <= slot_on(slot_enable, slot_ff) & sh_ff[15];
            sdo_oe_ff <= slot_on(slot_enable, slot_ff) | ~output_idle_mode_bit;
        end
        else if (!in_frame_ff && !ld_pend_ff)
        begin
            sdo_ff    <= 1'b0;
            sdo_oe_ff <= ~output_idle_mode_bit;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// occupancy, 4 words each way; full rx half loses its oldest
reg [2:0] nxt_tx_cnt, nxt_rx_cnt;
reg       nxt_hold_vld;

always @*
begin
    nxt_tx_cnt = tx_cnt_ff + {2'h0, usr_wr} - {2'h0, eng_wr & cur_taken_ff};
    nxt_rx_cnt = rx_cnt_ff - {2'h0, drn_issue};
    if (eng_wr && (nxt_rx_cnt != `CSB_BUF_WORDS))
        nxt_rx_cnt = nxt_rx_cnt + 3'h1;
    nxt_hold_vld = (hold_vld_ff & ~usr_wr) | (tx_valid & tx_ready_ff);
end

always @(posedge clk)
begin
    if (!nrst || !en)
    begin
        cnt_ff      <= `CSB_RST_PTR;
        tx_cnt_ff   <= `CSB_RST_CNT;
        rx_cnt_ff   <= `CSB_RST_CNT;
        hold_vld_ff <= 1'b0;
        tx_ready_ff <= 1'b0;
        drn_tag_ff  <= 1'b0;
        ovf_ff      <= 1'b0;
    end
    else
    begin
        if (eng_wr)
            cnt_ff <= cnt_ff + 2'h1;
        tx_cnt_ff   <= nxt_tx_cnt;
        rx_cnt_ff   <= nxt_rx_cnt;
        hold_vld_ff <= nxt_hold_vld;
        tx_ready_ff <= ~nxt_hold_vld & (nxt_tx_cnt != `CSB_BUF_WORDS);
        drn_tag_ff  <= drn_issue;
        ovf_ff      <= eng_wr & ~drn_issue & (rx_cnt_ff == `CSB_BUF_WORDS);
    end
end

// holding word avoids the engine's write slot
always @(posedge clk)
begin
    if (!nrst)
        hold_ff <= `CSB_RST_WORD;
    else if (tx_valid && tx_ready_ff && !(hold_vld_ff && !usr_wr))
        hold_ff <= tx_data;
end

// rx words leave by a two-entry buffer; stalls back up into memory
csb_pair_buf u_rx_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (drn_tag_ff),
    .in_ready  (buf_ready),
    .in_data   (mem_rdata),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
);

////////////////////////////////////////////////////////////////////////////////
// clock and sync pins; enables low while off
always @(posedge clk)
begin
    if (!nrst)
    begin
        sck_o_ff  <= 1'b0;
        sck_oe_ff <= 1'b0;
        fs_o_ff   <= 1'b0;
        fs_oe_ff  <= 1'b0;
    end
    else
    begin
        sck_o_ff  <= bck_gen_ff;
        sck_oe_ff <= en & ~ck_in;
        fs_o_ff   <= fs_gen_ff;
        fs_oe_ff  <= en & ~fs_in;
    end
end

assign tx_ready                = tx_ready_ff;
assign tx_underflow            = udf_ff;
assign rx_overflow             = ovf_ff;
assign serial_bit_clock_pin_o  = sck_o_ff;
assign serial_bit_clock_pin_oe = sck_oe_ff;
assign frame_sync_pin_o        = fs_o_ff;
assign frame_sync_pin_oe       = fs_oe_ff;
assign serial_data_out_pin_o   = sdo_ff;
assign serial_data_out_pin_oe  = sdo_oe_ff;

endmodule
`default_nettype wire

// >>> design/csb_pair_buf.v
`timescale 1ns/1ns
`default_nettype none
`include "csb_consts.vh"

module csb_pair_buf (
    // clock and reset
    input  wire                    clk,
    input  wire                    nrst,
    // filling side
    input  wire                    in_valid,
    output wire                    in_ready,
    input  wire [`CSB_WORD_W-1:0]  in_data,
    // draining side
    output wire                    out_valid,
    input  wire                    out_ready,
    output wire [`CSB_WORD_W-1:0]  out_data
);

////////////////////////////////////////////////////////////////////////////////
reg                    v0_ff, v1_ff, rdy_ff;
reg [`CSB_WORD_W-1:0]  d0_ff, d1_ff;
reg                    nxt_v0, nxt_v1;
reg [`CSB_WORD_W-1:0]  nxt_d0, nxt_d1;
wire                   push = in_valid & rdy_ff;
wire                   pop  = v0_ff & out_ready;

assign in_ready  = rdy_ff;
assign out_valid = v0_ff;
assign out_data  = d0_ff;

// head in slot 0; slot 1 fills only while it stalls
always @*
begin
    nxt_v0 = v0_ff;
    nxt_v1 = v1_ff;
    nxt_d0 = d0_ff;
    nxt_d1 = d1_ff;
    if (pop)
    begin
        nxt_v0 = v1_ff | push;
        nxt_d0 = v1_ff ? d1_ff : in_data;
        nxt_v1 = v1_ff & push;
        nxt_d1 = in_data;
    end
    else if (push)
    begin
        if (!v0_ff)
        begin
            nxt_v0 = 1'b1;
            nxt_d0 = in_data;
        end
        else
        begin
            nxt_v1 = 1'b1;
            nxt_d1 = in_data;
        end
    end
end

// ready registered so the filler sees a clean level
always @(posedge clk)
begin
    if (!nrst)
    begin
        v0_ff  <= 1'b0;
        v1_ff  <= 1'b0;
        rdy_ff <= 1'b0;
        d0_ff  <= `CSB_RST_WORD;
        d1_ff  <= `CSB_RST_WORD;
    end
    else
    begin
        v0_ff  <= nxt_v0;
        v1_ff  <= nxt_v1;
        rdy_ff <= ~nxt_v1;
        d0_ff  <= nxt_d0;
        d1_ff  <= nxt_d1;
    end
end

endmodule
`default_nettype wire

// >>> design/csb_shadow_mem.v
`timescale 1ns/1ns
`default_nettype none
`include "csb_consts.vh"

module csb_shadow_mem (
    // clock
    input  wire                    clk,
    // write port
    input  wire                    wr_en,
    input  wire [`CSB_MEM_AW-1:0]  wr_addr,
    input  wire [`CSB_WORD_W-1:0]  wr_data,
    // read port, data registered
    input  wire                    rd_en,
    input  wire [`CSB_MEM_AW-1:0]  rd_addr,
    output reg  [`CSB_WORD_W-1:0]  rd_data_ff
);

////////////////////////////////////////////////////////////////////////////////
// lower half received words, upper half words to send
reg [`CSB_WORD_W-1:0] mem_ff [0:(1<<`CSB_MEM_AW)-1];

// read before write: same address returns the old word
always @(posedge clk)
begin
    if (wr_en)
        mem_ff[wr_addr] <= wr_data;
    if (rd_en)
        rd_data_ff <= mem_ff[rd_addr];
end

endmodule
`default_nettype wire

// >>> include/csb_consts.vh
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH

// word and shadow memory geometry
`define CSB_WORD_W          16
`define CSB_MEM_AW          3
`define CSB_RX_AREA         1'h0
`define CSB_TX_AREA         1'h1
`define CSB_BUF_WORDS       3'h4

// timing: system clock period and least bit clock half period
`define CSB_CLK_PERIOD_NS   20
`define CSB_BCK_HALF_NS     80
`define CSB_BCK_HALF_CYC    ((`CSB_BCK_HALF_NS + `CSB_CLK_PERIOD_NS - 1) / `CSB_CLK_PERIOD_NS)

// framing styles
`define CSB_MODE_MULTI      2'h0
`define CSB_MODE_I2S        2'h1
`define CSB_MODE_AC16       2'h2
`define CSB_MODE_AC20       2'h3

// link sync high for the last bit and 15 more
`define CSB_AC_SYNC_LAST    8'h0e

// reset values
`define CSB_RST_WORD        16'h0000
`define CSB_RST_PTR         2'h0
`define CSB_RST_CNT         3'h0

`endif

// >>> sim/csb_codec_model.sv
`timescale 1ns/1ns
`default_nettype none
module csb_codec_model (
    // pins seen from the codec
    output logic bck,
    output logic fs,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic [255:0] got;  // first bit at 255; frame <= 256 bits
    logic [255:0] gote; // data out enable per bit
    initial {bck, fs, sdi} = 3'h0;
    // sync bit then n bits; clock idle between frames
    task automatic frame(input int n, input logic [255:0] d);
        #7;
        bck = 1'b1;
        fs = 1'b1; // pulse in the bit before slot 0
        #80 bck = 1'b0;
        #80;
        for (int i = 0; i < n; i++)
        begin
            bck = 1'b1; // codec supplies the bit clock
            fs = 1'b0;
            sdi = d[255-i]; // msb first, changed on rising
            #80 bck = 1'b0;
            got[255-i] = sdo;
            gote[255-i] = sdo_oe;
            #80;
        end
        sdi = ~sdi; // released, no pull: inverse
    endtask
endmodule
`default_nettype wire

// >>> sim/csb_converter_serial_block_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_consts.vh"
module csb_converter_serial_block_test;
    // design inputs
    logic clk, nrst, module_enable, output_idle_mode_bit;
    logic bit_clock_direction_bit, frame_sync_direction_bit;
    logic [1:0] frame_mode;
    logic [3:0] word_len_m1, slots_m1;
    logic [15:0] slot_enable, tx_data;
    logic tx_valid, rx_ready;
    // design outputs and pins
    wire logic tx_ready, rx_valid, tx_underflow, rx_overflow, m_bck, m_fs, m_sdi;
    wire logic [15:0] rx_data;
    wire logic serial_bit_clock_pin_o, serial_bit_clock_pin_oe, frame_sync_pin_o, frame_sync_pin_oe;
    wire logic serial_data_out_pin_o, serial_data_out_pin_oe;
    wire logic serial_bit_clock_pin_i = serial_bit_clock_pin_oe ? serial_bit_clock_pin_o : m_bck;
    wire logic frame_sync_pin_i = frame_sync_pin_oe ? frame_sync_pin_o : m_fs;
    wire logic serial_data_in_pin_i = m_sdi;
    int error_cnt = 0, check_count = 0, cyc = 0;
    bit ovf_seen, unf_seen;
    logic [15:0] q[$];
    csb_converter_serial_block i_csb_converter_serial_block (.*);
    csb_codec_model i_csb_codec_model (
        .bck    (m_bck),
        .fs     (m_fs),
        .sdi    (m_sdi),
        .sdo    (serial_data_out_pin_o),
        .sdo_oe (serial_data_out_pin_oe)
    );
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // status pulses and hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (rx_overflow === 1'b1) ovf_seen = 1;
        if (tx_underflow === 1'b1) unf_seen = 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("MISMATCH %0t run too long", $time);
            give_verdict;
        end
    end
    ////////////////////////////////////////
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    // disable resets the engine: clean start
    task automatic cfg(input logic dir, idle, input logic [1:0] fm, input logic [3:0] wl, sl, input logic [15:0] se);
        module_enable = 1'b0;
        {bit_clock_direction_bit, frame_sync_direction_bit, output_idle_mode_bit} = {dir, dir, idle};
        {frame_mode, word_len_m1, slots_m1, slot_enable} = {fm, wl, sl, se};
        step(2);
        module_enable = 1'b1;
        step(3);
    endtask
    task automatic push(input logic [15:0] d, output bit ok);
        ok = 1'b0;
        for (int k = 0; k < 6 && !ok; k++)
        begin
            ok = (tx_ready === 1'b1);
            {tx_valid, tx_data} = {ok, d};
            step;
        end
        tx_valid = 1'b0;
    endtask
    task automatic drain;
        int idle = 0;
        q = {};
        rx_ready = 1'b1;
        while (idle < 20)
        begin
            if (rx_valid === 1'b1) q.push_back(rx_data);
            idle = (rx_valid === 1'b1) ? 0 : idle + 1;
            step;
        end
        rx_ready = 1'b0;
    endtask
    task automatic run(input int n, input logic [255:0] d);
        i_csb_codec_model.frame(n, d);
        step(2);
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        step(3);
        chk(tx_ready === 1'b0 && serial_data_out_pin_oe === 1'b0, "reset outputs");
        nrst = 1'b1;
        step(4);
        chk({serial_bit_clock_pin_oe, frame_sync_pin_oe, serial_data_out_pin_oe} === 3'h0, "off pins");
        cfg(1'b1, 1'b1, 2'h0, 4'hf, 4'h0, 16'h0001);
        chk({serial_bit_clock_pin_oe, frame_sync_pin_oe, tx_ready} === 3'h1, "input pins");
        $display("t_reset done");
    endtask
    task automatic t_word;
        bit ok;
        cfg(1'b1, 1'b1, 2'h0, 4'hf, 4'h0, 16'h0001);
        push(16'ha5c3, ok);
        run(16, {16'h3c96, 240'h0});
        drain;
        chk(i_csb_codec_model.got[255:240] === 16'ha5c3, "sent word");
        chk(i_csb_codec_model.gote[255:240] === 16'hffff, "data out driven");
        chk(q.size() == 1 && q[0] === 16'h3c96, "received word");
        $display("t_word done");
    endtask
    task automatic t_short;
        bit ok;
        cfg(1'b1, 1'b1, 2'h0, 4'hb, 4'h1, 16'h0003);
        push(16'h1234, ok);
        push(16'habcf, ok);
        run(24, {24'hfed987, 232'h0});
        drain;
        chk(i_csb_codec_model.got[255:232] === 24'h123abc, "short sent");
        chk(q.size() == 2 && q[0] === 16'hfed0 && q[1] === 16'h9870, "short received");
        $display("t_short done");
    endtask
    task automatic t_idle;
        bit ok;
        for (int i = 0; i < 2; i++)
        begin
            cfg(1'b1, i[0], 2'h0, 4'h7, 4'h1, 16'h0001);
            push(16'h5a00, ok);
            run(16, {16'hc377, 240'h0});
            drain;
            chk(i_csb_codec_model.got[255:248] === 8'h5a, "slot 0 sent");
            chk(i_csb_codec_model.gote[247:240] === {8{~i[0]}}, "idle enable");
            chk(i[0] || i_csb_codec_model.got[247:240] === 8'h00, "idle low");
            chk(q.size() == 1 && q[0] === 16'hc300, "slot 0 only");
        end
        $display("t_idle done");
    endtask
    task automatic t_fill;
        bit ok;
        int n;
        cfg(1'b1, 1'b1, 2'h0, 4'hf, 4'h3, 16'h000f);
        n = 0;
        ok = 1'b1;
        for (int k = 0; k < 8 && ok; k++)
        begin
            push(16'h11a0 + k[15:0], ok);
            n += ok;
        end
        chk(n >= 4 && n <= 5, "tx words held");
        {ovf_seen, unf_seen} = 2'b00;
        run(64, {64'ha000a001a002a003, 192'h0});
        chk(i_csb_codec_model.got[255:192] === 64'h11a011a111a211a3, "slot order");
        run(64, {64'hb000b001b002b003, 192'h0});
        drain;
        chk(unf_seen, "underflow");
        chk(ovf_seen && q.size() == 6 && q[0] === 16'ha000, "rx hold count");
        $display("t_fill done");
    endtask
    task automatic t_master;
        int tog, fsc;
        logic b, f;
        for (int m = 0; m < 4; m++)
        begin
            cfg(1'b0, 1'b0, m[1:0], 4'hf, 4'h1, 16'h0000);
            {tog, fsc} = 0;
            for (int k = 0; k < 600; k++)
            begin
                {b, f} = {serial_bit_clock_pin_o, frame_sync_pin_o};
                step;
                tog += (b !== serial_bit_clock_pin_o);
                fsc += (f !== frame_sync_pin_o);
            end
            chk(tog == 150 && serial_bit_clock_pin_oe === 1'b1, "own bit clock");
            chk(fsc >= 2 && frame_sync_pin_oe === 1'b1, "own frame sync");
        end
        $display("t_master done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        {nrst, module_enable, tx_valid, rx_ready, tx_data, frame_mode, word_len_m1, slots_m1, slot_enable} = 0;
        {bit_clock_direction_bit, frame_sync_direction_bit, output_idle_mode_bit} = 3'h7;
        t_reset;
        t_word;
        t_short;
        t_idle;
        t_fill;
        t_master;
        give_verdict;
    end
endmodule
`default_nettype wire

// >>> sim/csb_serial_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_consts.vh"
module csb_serial_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // configuration
    input wire logic module_enable,
    input wire logic bit_clock_direction_bit,
    input wire logic frame_sync_direction_bit,
    input wire logic output_idle_mode_bit,
    input wire logic [3:0] word_len_m1,
    // word streams
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [`CSB_WORD_W-1:0] rx_data,
    input wire logic rx_overflow,
    // pins
    input wire logic serial_bit_clock_pin_i,
    input wire logic serial_bit_clock_pin_o,
    input wire logic serial_bit_clock_pin_oe,
    input wire logic frame_sync_pin_oe,
    input wire logic serial_data_out_pin_o,
    input wire logic serial_data_out_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // pin ownership once configs settle
    property p_pins_free;
        !module_enable ##1 !module_enable |-> !serial_bit_clock_pin_oe && !frame_sync_pin_oe && !serial_data_out_pin_oe;
    endproperty
    a_pins_free: assert property (p_pins_free) else $error("pin driven off");
    property p_bck_dir;
        (module_enable && $stable(bit_clock_direction_bit))[*3] |->
            serial_bit_clock_pin_oe == !bit_clock_direction_bit;
    endproperty
    a_bck_dir: assert property (p_bck_dir) else $error("clock direction");
    property p_fs_dir;
        (module_enable && $stable(frame_sync_direction_bit))[*3] |->
            frame_sync_pin_oe == !frame_sync_direction_bit;
    endproperty
    a_fs_dir: assert property (p_fs_dir) else $error("sync direction");
    // own bit clock: four-cycle halves
    property p_bck_half;
        disable iff (!nrst || !module_enable || bit_clock_direction_bit)
        $changed(serial_bit_clock_pin_o) |=>
            $stable(serial_bit_clock_pin_o)[*3] ##1 $changed(serial_bit_clock_pin_o);
    endproperty
    a_bck_half: assert property (p_bck_half) else $error("clock half");
    ////////////////////////////////////////
    // word streams
    property p_tx_gap;
        tx_valid && tx_ready |=> !tx_ready;
    endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("tx ready after take");
    property p_rx_hold;
        rx_valid && !rx_ready && module_enable |=> rx_valid && $stable(rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");
    property p_rx_just;
        rx_valid && module_enable |->
            (rx_data & (16'hffff >> ({1'b0, word_len_m1} + 5'h01))) == 16'h0000;
    endproperty
    a_rx_just: assert property (p_rx_just) else $error("rx low bits not zero");
    ////////////////////////////////////////
    // data out drive and hold
    property p_idle_drive;
        (module_enable && !output_idle_mode_bit)[*3] |-> serial_data_out_pin_oe;
    endproperty
    a_idle_drive: assert property (p_idle_drive) else $error("data out not driven");
    property p_sdo_hold;
        $fell(serial_bit_clock_pin_i) && module_enable && bit_clock_direction_bit |=>
            ##1 $stable(serial_data_out_pin_o)[*3];
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("data out moved");
    c_tx_take: cover property (tx_valid && tx_ready);
    c_rx_take: cover property (rx_valid && rx_ready);
    c_overflow: cover property (rx_overflow);
endmodule
bind csb_converter_serial_block csb_serial_assertions i_csb_serial_assertions (.*);
`default_nettype wire
